//--- verilog/sdc_pkg.sv
// Shared constants for the DRAM controller and the memory device end
package sdc_pkg;
    localparam int ADDR_W = 12;
    localparam int COL_W = 9;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int DATA_W = 16;
    localparam int NBYTE = 2;
    localparam int MEM_IDX_W = 8;
    localparam int CNT_W = 15;
    // Command codes as {row_strobe_n, column_strobe_n, write_strobe_n}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Address field positions and values
    localparam int ALL_BANKS_BIT = 10;
    localparam int CL_LSB = 4;
    localparam int CL_W = 3;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam logic [11:0] PRE_ALL_ADDR = 12'h400;
    localparam logic [11:0] MODE_WORD = 12'h020;
    localparam logic [11:0] MODE_RESET = 12'h000;
    // Timing, clock period 10 ns
    localparam int CLK_NS = 10;
    localparam int T_PAUSE_US = 200;
    localparam int PAUSE_CYC = (T_PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int T_RCD_NS = 15;
    localparam int T_RC_NS = 60;
    localparam int T_RP_NS = 15;
    localparam int T_WR_NS = 15;
    localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC = 2;
    localparam int CL_CYC = 2;
    localparam int REF_COUNT = 8;
    // Request word layout in the command FIFO
    localparam int FIFO_DEPTH = 8;
    localparam int REQ_W = 40;
    localparam int REQ_DATA_LSB = 0;
    localparam int REQ_COL_LSB = 16;
    localparam int REQ_ROW_LSB = 25;
    localparam int REQ_BANK_LSB = 37;
    localparam int REQ_WR_BIT = 39;
endpackage : sdc_pkg

//--- verilog/sdc_link_if.sv
// Pin-level link between the DRAM controller and the memory device
`timescale 1ns/100ps
interface sdc_link_if;
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic clock_gate_enable;
    logic [1:0] bank_select_lines;
    logic [11:0] address_lines;
    logic [1:0] byte_mask;
    logic [15:0] ctl_dq_out;
    logic ctl_dq_oe_n;
    logic [15:0] dev_dq_out;
    logic [1:0] dev_dq_oe_n;
    logic [15:0] data_lines;

    // Bus level per byte; an undriven byte reads as zero
    assign data_lines[7:0] = !ctl_dq_oe_n ? ctl_dq_out[7:0] :
        !dev_dq_oe_n[0] ? dev_dq_out[7:0] : 8'h00;
    assign data_lines[15:8] = !ctl_dq_oe_n ? ctl_dq_out[15:8] :
        !dev_dq_oe_n[1] ? dev_dq_out[15:8] : 8'h00;

    modport host (
        output chip_select_n, row_strobe_n, column_strobe_n,
        output write_strobe_n, clock_gate_enable, bank_select_lines,
        output address_lines, byte_mask, ctl_dq_out, ctl_dq_oe_n,
        input data_lines
    );
    modport dev (
        input chip_select_n, row_strobe_n, column_strobe_n,
        input write_strobe_n, clock_gate_enable, bank_select_lines,
        input address_lines, byte_mask, data_lines,
        output dev_dq_out, dev_dq_oe_n
    );
endinterface : sdc_link_if

//--- verilog/sdc_fifo.sv
// Request FIFO with valid and ready on both sides
`timescale 1ns/100ps
module sdc_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW:0] wr_ptr_ff;
    logic [PW:0] rd_ptr_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire ptr_same = wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0];

    assign out_valid = wr_ptr_ff != rd_ptr_ff;
    assign in_ready = !(ptr_same && (wr_ptr_ff[PW] != rd_ptr_ff[PW]));
    assign out_data = mem[rd_ptr_ff[PW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_ff[PW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (PW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (PW+1)'(pop);
        end
    end
endmodule : sdc_fifo

//--- verilog/sdc_device.sv
// Memory device end: command decode, banks, mode word, data pins
`timescale 1ns/100ps
module sdc_device (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link to the controller
    sdc_link_if.dev link,
    // Device state
    output logic [sdc_pkg::ADDR_W-1:0] mode_word,
    output logic mode_loaded,
    output logic [sdc_pkg::NBANK-1:0] bank_open,
    output logic [1:0] power_state
);
    import sdc_pkg::*;

    typedef enum logic [1:0] {P_RUN, P_PDOWN, P_SUSP, P_SREF} sdc_pwr_t;

    function automatic logic [MEM_IDX_W-1:0] mem_index(
        input logic [BANK_W-1:0] ba,
        input logic [ADDR_W-1:0] row,
        input logic [ADDR_W-1:0] col
    );
        mem_index = {ba, row[1:0], col[3:0]};
    endfunction : mem_index

    logic [DATA_W-1:0] mem [0:(1<<MEM_IDX_W)-1];
    logic [ADDR_W-1:0] row_ff [0:NBANK-1];
    logic [NBANK-1:0] open_ff;
    logic [ADDR_W-1:0] mode_ff;
    logic mode_ok_ff;
    logic [2:0] rdv_ff;
    logic [DATA_W-1:0] rdd_ff [0:2];
    logic [NBYTE-1:0] dqm_d1_ff;
    logic [NBYTE-1:0] dqm_d2_ff;
    sdc_pwr_t pwr_ff;
    sdc_pwr_t nxt_pwr;

    // Clocking stops unless running with the gate enable high
    wire run = (pwr_ff == P_RUN) & link.clock_gate_enable;
    wire live = run & ~link.chip_select_n;
    wire [2:0] cmd = {link.row_strobe_n, link.column_strobe_n,
        link.write_strobe_n};
    wire [BANK_W-1:0] ba = link.bank_select_lines;
    wire [ADDR_W-1:0] col = {3'h0, link.address_lines[COL_W-1:0]};
    wire [MEM_IDX_W-1:0] idx = mem_index(ba, row_ff[ba], col);
    wire bank_ok = open_ff[ba];
    wire do_act = live & (cmd == CMD_ACT) & ~bank_ok;
    wire do_pre = live & (cmd == CMD_PRE);
    wire do_mrs = live & (cmd == CMD_MRS) & ~|open_ff;
    wire do_rd = live & (cmd == CMD_RD) & bank_ok;
    wire do_wr = live & (cmd == CMD_WR) & bank_ok;
    wire [DATA_W-1:0] old_word = mem[idx];
    wire [DATA_W-1:0] wr_word;
    wire cl3 = mode_ff[CL_LSB +: CL_W] == CL_THREE;
    wire out_v = cl3 ? rdv_ff[2] : rdv_ff[1];
    wire [DATA_W-1:0] out_d = cl3 ? rdd_ff[2] : rdd_ff[1];

    genvar b;
    generate
        for (b = 0; b < NBYTE; b++)
        begin : g_byte
            // Masked byte keeps its old value, no latency
            assign wr_word[b*8 +: 8] = link.byte_mask[b] ?
                old_word[b*8 +: 8] : link.data_lines[b*8 +: 8];
            // Masked byte floats two cycles after the mask
            assign link.dev_dq_oe_n[b] = ~(out_v & ~dqm_d2_ff[b]);
        end
    endgenerate

    assign link.dev_dq_out = out_d;
    assign mode_word = mode_ff;
    assign mode_loaded = mode_ok_ff;
    assign bank_open = open_ff;
    assign power_state = pwr_ff;

    // Low-power entry depends on state and command
    always_comb
    begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            P_RUN:
            begin
                if (!link.clock_gate_enable)
                begin
                    if (!link.chip_select_n && cmd == CMD_REF)
                        nxt_pwr = P_SREF;
                    else if (|rdv_ff)
                        nxt_pwr = P_SUSP;
                    else
                        nxt_pwr = P_PDOWN;
                end
            end
            P_PDOWN, P_SUSP, P_SREF:
            begin
                if (link.clock_gate_enable)
                    nxt_pwr = P_RUN;
            end
            default: nxt_pwr = P_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[idx] <= wr_word;
        if (run)
            rdd_ff[0] <= mem[idx];
        if (run)
            rdd_ff[1] <= rdd_ff[0];
        if (run)
            rdd_ff[2] <= rdd_ff[1];
    end

    generate
        for (b = 0; b < NBANK; b++)
        begin : g_bank
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    row_ff[b] <= '0;
                else if (do_act && ba == BANK_W'(b))
                    row_ff[b] <= link.address_lines;
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            open_ff <= '0;
            mode_ff <= MODE_RESET;
            mode_ok_ff <= 1'b0;
            rdv_ff <= '0;
            dqm_d1_ff <= '0;
            dqm_d2_ff <= '0;
            pwr_ff <= P_RUN;
        end
        else
        begin
            pwr_ff <= nxt_pwr;
            if (do_act)
                open_ff[ba] <= 1'b1;
            else if (do_pre && link.address_lines[ALL_BANKS_BIT])
                open_ff <= '0;
            else if (do_pre)
                open_ff[ba] <= 1'b0;
            if (do_mrs)
            begin
                mode_ff <= link.address_lines;
                mode_ok_ff <= 1'b1;
            end
            if (run)
            begin
                rdv_ff <= {rdv_ff[1:0], do_rd};
                dqm_d1_ff <= link.byte_mask;
                dqm_d2_ff <= dqm_d1_ff;
            end
        end
    end
endmodule : sdc_device

//--- verilog/sdc_ctrl.sv
// DRAM controller end: power-up sequence and single-word accesses
//
// How it works
// - Row on twelve lines, column on nine
// - Bank lines pick bank for activate, access
// - Deselected chip ignores new commands
// - Three strobes decoded at each edge
// - Read mask floats byte two cycles later
// - Write mask blocks byte immediately
// - Low gate enable enters a low-power mode
// - Mode word undefined until programmed
// - Pause 200 us, then precharge all banks
// - Masks and gate enable high during pause
// - Mode set after all banks precharged
// - Eight auto refresh cycles during start-up
// - Mode set only idle, gate enable high
// - All four strobes low loads mode word
// - Wait mode-set delay before next command
// - Activate first, wait row-to-column delay
// - Precharge before activating a bank again
// - Same-bank activates spaced by row cycle
// - Bank-to-bank activates spaced by delay
// - Bank never open beyond row active time
// - Column access encoding, write strobe selects
// - Accesses accepted on every clock cycle; this controller issues one access per activate and precharge
// - Write data driven with the write command
`timescale 1ns/100ps
module sdc_ctrl #(
    parameter int PAUSE_CYCLES = sdc_pkg::PAUSE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [sdc_pkg::BANK_W-1:0] req_bank,
    input wire logic [sdc_pkg::ADDR_W-1:0] req_row,
    input wire logic [sdc_pkg::COL_W-1:0] req_col,
    input wire logic [sdc_pkg::DATA_W-1:0] req_wdata,
    // Answer side
    output logic [sdc_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic init_done,
    // Link to the device
    sdc_link_if.host link
);
    import sdc_pkg::*;

    typedef enum logic [3:0] {
        C_PAUSE,
        C_REF,
        C_MRS,
        C_IDLE,
        C_ACT,
        C_ACCESS,
        C_RDWAIT,
        C_PRE,
        C_WAIT
    } sdc_ctl_state_t;

    sdc_ctl_state_t state_ff;
    sdc_ctl_state_t nxt_state;
    sdc_ctl_state_t ret_ff;
    sdc_ctl_state_t nxt_ret;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [3:0] ref_ff;
    logic [3:0] nxt_ref;
    logic [2:0] cmd_ff;
    logic [2:0] nxt_cmd;
    logic [BANK_W-1:0] ba_ff;
    logic [BANK_W-1:0] nxt_ba;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [NBYTE-1:0] dqm_ff;
    logic [NBYTE-1:0] nxt_dqm;
    logic [DATA_W-1:0] dq_out_ff;
    logic [DATA_W-1:0] nxt_dq_out;
    logic dq_oe_n_ff;
    logic nxt_dq_oe_n;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic init_ff;
    logic nxt_init;
    logic [REQ_W-1:0] req_ff;
    logic [REQ_W-1:0] nxt_req;

    wire fifo_valid;
    wire [REQ_W-1:0] fifo_data;
    wire [REQ_W-1:0] push_word = {req_write, req_bank, req_row,
        req_col, req_wdata};
    // Only an idle controller drains the FIFO
    wire fifo_pop = state_ff == C_IDLE;
    wire cnt_done = cnt_ff == '0;
    wire last_ref = ref_ff == 4'(REF_COUNT - 1);
    wire req_is_wr = req_ff[REQ_WR_BIT];
    wire [BANK_W-1:0] req_ba = req_ff[REQ_BANK_LSB +: BANK_W];
    wire [ADDR_W-1:0] req_rw = req_ff[REQ_ROW_LSB +: ADDR_W];
    wire [ADDR_W-1:0] req_cl = {3'h0, req_ff[REQ_COL_LSB +: COL_W]};
    wire [DATA_W-1:0] req_dt = req_ff[REQ_DATA_LSB +: DATA_W];

    sdc_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(push_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Pins: chip always selected, gate enable always high
    assign link.chip_select_n = 1'b0;
    assign link.clock_gate_enable = 1'b1;
    assign {link.row_strobe_n, link.column_strobe_n,
        link.write_strobe_n} = cmd_ff;
    assign link.bank_select_lines = ba_ff;
    assign link.address_lines = addr_ff;
    assign link.byte_mask = dqm_ff;
    assign link.ctl_dq_out = dq_out_ff;
    assign link.ctl_dq_oe_n = dq_oe_n_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign init_done = init_ff;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        nxt_ref = ref_ff;
        nxt_cmd = CMD_NOP;
        nxt_ba = ba_ff;
        nxt_addr = addr_ff;
        nxt_dqm = dqm_ff;
        nxt_dq_out = dq_out_ff;
        nxt_dq_oe_n = 1'b1;
        nxt_rd_data = rd_data_ff;
        nxt_rd_valid = 1'b0;
        nxt_init = init_ff;
        nxt_req = req_ff;
        case (state_ff)
            C_PAUSE:
            begin
                if (cnt_done)
                begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr = PRE_ALL_ADDR;
                    nxt_dqm = '0;
                    nxt_cnt = CNT_W'(RP_CYC - 1);
                    nxt_ret = C_REF;
                    nxt_state = C_WAIT;
                end
            end
            C_REF:
            begin
                nxt_cmd = CMD_REF;
                nxt_ref = ref_ff + 4'h1;
                nxt_cnt = CNT_W'(RC_CYC - 1);
                nxt_ret = last_ref ? C_MRS : C_REF;
                nxt_state = C_WAIT;
            end
            C_MRS:
            begin
                // Every bank closed by the earlier precharge-all
                nxt_cmd = CMD_MRS;
                nxt_addr = MODE_WORD;
                nxt_ba = '0;
                nxt_cnt = CNT_W'(MRD_CYC - 1);
                nxt_ret = C_IDLE;
                nxt_state = C_WAIT;
            end
            C_IDLE:
            begin
                nxt_init = 1'b1;
                if (fifo_valid)
                begin
                    nxt_req = fifo_data;
                    nxt_state = C_ACT;
                end
            end
            C_ACT:
            begin
                nxt_cmd = CMD_ACT;
                nxt_ba = req_ba;
                nxt_addr = req_rw;
                nxt_cnt = CNT_W'(RCD_CYC - 1);
                nxt_ret = C_ACCESS;
                nxt_state = C_WAIT;
            end
            C_ACCESS:
            begin
                nxt_cmd = req_is_wr ? CMD_WR : CMD_RD;
                nxt_addr = req_cl;
                if (req_is_wr)
                begin
                    nxt_dq_out = req_dt;
                    nxt_dq_oe_n = 1'b0;
                    nxt_cnt = CNT_W'(WR_CYC - 1);
                    nxt_ret = C_PRE;
                    nxt_state = C_WAIT;
                end
                else
                begin
                    nxt_cnt = CNT_W'(CL_CYC);
                    nxt_state = C_RDWAIT;
                end
            end
            C_RDWAIT:
            begin
                if (cnt_done)
                begin
                    nxt_rd_data = link.data_lines;
                    nxt_rd_valid = 1'b1;
                    nxt_state = C_PRE;
                end
            end
            C_PRE:
            begin
                // Closed page: bank shut after one access
                nxt_cmd = CMD_PRE;
                nxt_addr = '0;
                nxt_cnt = CNT_W'(RC_CYC - 1);
                nxt_ret = C_IDLE;
                nxt_state = C_WAIT;
            end
            C_WAIT:
            begin
                if (cnt_done)
                    nxt_state = ret_ff;
            end
            default: nxt_state = C_PAUSE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= C_PAUSE;
            ret_ff <= C_PAUSE;
            cnt_ff <= CNT_W'(PAUSE_CYCLES - 1);
            ref_ff <= 4'h0;
            cmd_ff <= CMD_NOP;
            ba_ff <= '0;
            addr_ff <= '0;
            dqm_ff <= 2'h3;
            dq_out_ff <= '0;
            dq_oe_n_ff <= 1'b1;
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b0;
            init_ff <= 1'b0;
            req_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            cnt_ff <= nxt_cnt;
            ref_ff <= nxt_ref;
            cmd_ff <= nxt_cmd;
            ba_ff <= nxt_ba;
            addr_ff <= nxt_addr;
            dqm_ff <= nxt_dqm;
            dq_out_ff <= nxt_dq_out;
            dq_oe_n_ff <= nxt_dq_oe_n;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            init_ff <= nxt_init;
            req_ff <= nxt_req;
        end
    end
endmodule : sdc_ctrl

//--- bench/sdc_link_monitor.sv
// Concurrent checks on the controller to device link
`timescale 1ns/100ps
module sdc_link_monitor #(
    parameter int PAUSE_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command pins
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic clock_gate_enable,
    input wire logic [1:0] bank_select_lines,
    input wire logic [11:0] address_lines,
    input wire logic [1:0] byte_mask,
    // Data pin enables
    input wire logic ctl_dq_oe_n,
    input wire logic [1:0] dev_dq_oe_n
);
    import sdc_pkg::*;
    logic [2:0] cmd;
    logic [3:0] sel_bank;
    logic [3:0] nxt_open;
    logic [31:0] cyc_ff;
    logic [3:0] open_ff;
    logic [3:0] ref_ff;
    logic seen_ff;
    assign cmd = (chip_select_n || !clock_gate_enable) ? CMD_NOP :
        {row_strobe_n, column_strobe_n, write_strobe_n};
    assign sel_bank = 4'h1 << bank_select_lines;
    assign nxt_open = (cmd == CMD_ACT) ? (open_ff | sel_bank) :
        (cmd != CMD_PRE) ? open_ff :
        address_lines[10] ? 4'h0 : (open_ff & ~sel_bank);
    // Power-up cycle count, banks open and refreshes seen on the pins
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cyc_ff <= '0;
            open_ff <= 4'h0;
            ref_ff <= 4'h0;
            seen_ff <= 1'b0;
        end
        else
        begin
            cyc_ff <= (cyc_ff < PAUSE_CYCLES) ? cyc_ff + 1 : cyc_ff;
            open_ff <= nxt_open;
            ref_ff <= ref_ff + 4'((cmd == CMD_REF));
            seen_ff <= seen_ff | (cmd != CMD_NOP);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_nop_pair;
        (cmd == CMD_NOP) [*2];
    endsequence
    sequence s_read_answer;
        ##2 (dev_dq_oe_n == $past(byte_mask, 2)) ##1 (dev_dq_oe_n == 2'h3);
    endsequence
    a_pause_quiet: assert property (
        cyc_ff < PAUSE_CYCLES - 1 |-> !chip_select_n && cmd == CMD_NOP &&
        byte_mask == 2'h3 && clock_gate_enable)
        else $error("link not quiet during power-up pause");
    a_first_precharge: assert property (
        !seen_ff && cmd != CMD_NOP |-> cmd == CMD_PRE && address_lines[10])
        else $error("first command is not precharge of all banks");
    a_mode_set_idle: assert property (
        cmd == CMD_MRS |-> open_ff == 4'h0 && $past(clock_gate_enable))
        else $error("mode set with a bank open");
    a_refresh_count: assert property (
        cmd == CMD_MRS |-> ref_ff == 4'h8)
        else $error("mode set not after eight refreshes");
    a_mode_set_gap: assert property (
        cmd == CMD_MRS |=> s_nop_pair)
        else $error("command too soon after mode set");
    a_access_after_act: assert property (
        cmd == CMD_RD || cmd == CMD_WR |-> open_ff[bank_select_lines] &&
        $past(cmd, 3) == CMD_ACT && $past(bank_select_lines, 3) ==
        bank_select_lines)
        else $error("access not three cycles after its activation");
    a_no_reactivate: assert property (
        cmd == CMD_ACT |-> !open_ff[bank_select_lines])
        else $error("activation of an open bank");
    a_act_spacing: assert property (
        cmd == CMD_ACT |=> (cmd != CMD_ACT) [*5])
        else $error("activations closer than the row cycle");
    a_write_data: assert property (
        cmd == CMD_WR |-> !ctl_dq_oe_n ##1 ctl_dq_oe_n)
        else $error("write data not driven for the write cycle only");
    a_read_answer: assert property (
        cmd == CMD_RD |-> s_read_answer)
        else $error("read data not driven two cycles after read");
endmodule : sdc_link_monitor

//--- bench/testbench.sv
// Testbench joining the controller and the memory device end
`timescale 1ns/100ps
module testbench;
    import sdc_pkg::*;
    localparam int PAUSE = 20;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_bank = 2'h0;
    logic [11:0] req_row = 12'h000;
    logic [8:0] req_col = 9'h000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready;
    logic [15:0] rd_data;
    logic rd_valid;
    logic init_done;
    logic [11:0] mode_word;
    logic mode_loaded;
    logic [3:0] bank_open;
    logic [1:0] power_state;
    logic [15:0] exp_q[$];
    logic [11:0] tb_row[8];
    logic [8:0] tb_col[8];
    logic [15:0] tb_data[8];
    int bad_count = 0;
    int num_checks = 0;
    sdc_link_if i_sdc_link_if();
    sdc_ctrl #(.PAUSE_CYCLES(PAUSE)) i_sdc_ctrl (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .init_done(init_done), .link(i_sdc_link_if));
    sdc_device i_sdc_device (.clk(clk), .reset(reset),
        .link(i_sdc_link_if), .mode_word(mode_word),
        .mode_loaded(mode_loaded), .bank_open(bank_open),
        .power_state(power_state));
    sdc_link_monitor #(.PAUSE_CYCLES(PAUSE)) i_sdc_link_monitor (
        .clk(clk), .reset(reset),
        .chip_select_n(i_sdc_link_if.chip_select_n),
        .row_strobe_n(i_sdc_link_if.row_strobe_n),
        .column_strobe_n(i_sdc_link_if.column_strobe_n),
        .write_strobe_n(i_sdc_link_if.write_strobe_n),
        .clock_gate_enable(i_sdc_link_if.clock_gate_enable),
        .bank_select_lines(i_sdc_link_if.bank_select_lines),
        .address_lines(i_sdc_link_if.address_lines),
        .byte_mask(i_sdc_link_if.byte_mask),
        .ctl_dq_oe_n(i_sdc_link_if.ctl_dq_oe_n),
        .dev_dq_oe_n(i_sdc_link_if.dev_dq_oe_n));
    always #5 clk = ~clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    end
    endtask : chk
    // Offer one request and hold it until taken
    task push(input logic w, input int i);
    begin
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= 2'(i);
        req_row <= tb_row[i];
        req_col <= tb_col[i];
        req_wdata <= tb_data[i];
        if (!w)
            exp_q.push_back(tb_data[i]);
        @(negedge clk);
        while (req_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
    end
    endtask : push
    task wait_idle(input logic for_init);
        int n;
    begin
        n = 0;
        req_valid <= 1'b0;
        while ((for_init ? init_done !== 1'b1 : exp_q.size() > 0) && n < 600)
        begin
            @(posedge clk);
            n++;
        end
        chk(16'(n < 600), 16'h0001);
    end
    endtask : wait_idle
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask : end_sim
    // Answer checker: oldest expected read word against each result
    always @(negedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            chk(16'(exp_q.size() > 0), 16'h0001);
            if (exp_q.size() > 0)
                chk(rd_data, exp_q.pop_front());
        end
    end
    initial
    begin
        #60000;
        bad_count++;
        end_sim;
    end
    initial
    begin
        void'($urandom(69));
        for (int i = 0; i < 8; i++)
        begin
            tb_row[i] = {10'($urandom), 1'b0, i[2]};
            tb_col[i] = 9'($urandom);
            tb_data[i] = 16'($urandom);
        end
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(16'({mode_loaded, bank_open}), 16'h0000);
        for (int i = 0; i < 8; i++)
            push(1'b1, i);
        @(negedge clk);
        chk(16'({req_ready, init_done}), 16'h0000);
        @(posedge clk);
        $display("test fill done");
        wait_idle(1'b1);
        chk(16'(mode_word), 16'(MODE_WORD));
        chk(16'(mode_loaded), 16'h0001);
        chk(16'(power_state), 16'h0000);
        for (int i = 0; i < 8; i++)
            push(1'b0, i);
        wait_idle(1'b0);
        // Last precharge reaches the device two edges after the answer
        repeat (2) @(negedge clk);
        chk(16'(bank_open), 16'h0000);
        @(posedge clk);
        $display("test readback done");
        for (int i = 0; i < 4; i++)
        begin
            tb_data[i] = 16'($urandom);
            push(1'b1, i);
            push(1'b0, i);
        end
        wait_idle(1'b0);
        $display("test write read pairs done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        chk(16'({mode_loaded, init_done, bank_open}), 16'h0000);
        reset <= 1'b0;
        @(posedge clk);
        wait_idle(1'b1);
        tb_data[6] = 16'($urandom);
        push(1'b1, 6);
        push(1'b0, 6);
        wait_idle(1'b0);
        $display("test second reset done");
        end_sim;
    end
endmodule : testbench
